// File: hdl/sclk_pkg.sv
// Shared constants and types for the stop-clock power control block
package sclk_pkg;
   localparam int ADDR_W = 30;
   localparam int DATA_W = 32;
   localparam logic [29:0] STOP_GRANT_ADDR = 30'h0000_0010;
   localparam logic [3:0] STOP_GRANT_BE = 4'hb;
   localparam logic [3:0] QUIET_BE = 4'hf;
   localparam int RESUME_CLKS = 12;
   localparam int REARM_CLKS = 5;
   localparam int DRAIN_CLKS = 4;
   localparam int CNT_W = 5;
   // Interrupt sources in arbitration
   typedef enum logic [2:0] {
      SCLK_SRC_NONE, SCLK_SRC_RESET, SCLK_SRC_FLUSH, SCLK_SRC_SOFT_RESET,
      SCLK_SRC_SMI, SCLK_SRC_NMI, SCLK_SRC_MASKABLE_INTERRUPT, SCLK_SRC_STOP
   } sclk_src_t;
   // Device stop-clock sequence states
   typedef enum logic [2:0] {
      SCLK_RUN, SCLK_DRAIN, SCLK_CYCLE, SCLK_WAIT_ACK, SCLK_GRANT,
      SCLK_RESUME
   } sclk_state_t;
endpackage

// File: hdl/sclk_link_if.sv
// Pins between the processor end and the chipset end
interface sclk_link_if;
   logic stop_clock_request_n;
   logic ready_n;
   logic burst_ready_n;
   logic hold;
   logic hold_acknowledge;
   logic address_strobe_n;
   logic [29:0] addr;
   logic [3:0] byte_enables_n;
   logic mem_io;
   logic data_code;
   logic write_read;
   logic [31:0] data_out;
   logic [31:0] data_in;
   logic data_oe;
   logic [3:0] data_parity;
   logic data_parity_oe;
   logic bus_lock_n;
   logic pseudo_bus_lock_n;
   logic addr_oe;
   logic stop_pullup_en;
   modport cpu (
      input stop_clock_request_n, ready_n, burst_ready_n, hold, data_in,
      output hold_acknowledge, address_strobe_n, addr, byte_enables_n,
      output mem_io, data_code, write_read, data_out, data_oe,
      output data_parity, data_parity_oe, bus_lock_n, pseudo_bus_lock_n,
      output addr_oe, stop_pullup_en
   );
   modport sys (
      output stop_clock_request_n, ready_n, burst_ready_n, hold, data_in,
      input hold_acknowledge, address_strobe_n, addr, byte_enables_n,
      input mem_io, data_code, write_read, data_out, data_oe,
      input data_parity, data_parity_oe, bus_lock_n, pseudo_bus_lock_n,
      input addr_oe, stop_pullup_en
   );
endinterface

// File: hdl/sclk_sync.sv
// Two-flop synchroniser for an asynchronous level
module sclk_sync #(
   parameter logic INIT = 1'b1
) (
   input wire logic clk, // Clock
   input wire logic reset, // Sync reset, high
   input wire logic d, // Async level
   output logic q // Synchronised level
);
   logic meta_r; // First stage, read only by second

   // Two stages; reset to idle level so nothing fires at start
   always_ff @(posedge clk) begin
      if (reset) begin
         meta_r <= INIT;
         q <= INIT;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// File: hdl/sclk_cpu.sv
// Processor end of the stop-clock sequence
// Summary of operation
// R1 - Halt at boundary, drain, grant cycle, stop clock
// R2 - Ignore stop request while hold acknowledged
// R3 - Resume after interrupted instruction on release
// R4 - No acknowledge cycle or vector read
// R5 - Write-through priority: reset, flush, SYSTEM_MGMT_INTERRUPT_N, NMI, MASKABLE_INTERRUPT, stop; code ranks soft reset above flush
// R6 - Write-back priority: reset, flush, soft reset, SYSTEM_MGMT_INTERRUPT_N...
// R7 - Stop request active low, asynchronous
// R8 - System holds request until grant acknowledged
// R9 - System drives request high to exit
// R10 - Request stays high five clocks after acknowledge
// R11 - Grant cycle: address 10h, enables 1011, write
// R12 - Enter grant only after ready or burst ready
// R13 - Hold address, enables, definition pins in grant
// R14 - Float data, parity; strobe and locks inactive
// R15 - Hold in grant: acknowledge and float bus
// R16 - Hold release restores prior pin states
// R17 - Pull-up off in grant; stopped clock deeper
// R18 - Phase one starts at each rising clock edge
// R19 - Return to run ten to twenty clocks after release
// R20 - Grant cycle only when entering from run or halt
// R21 - Two-flop synchroniser before recognition
module sclk_cpu (
   input wire logic clk, // Single 1X clock
   input wire logic reset, // Hard reset, high
   sclk_link_if.cpu link, // Bus pins
   input wire logic write_back_mode, // Cache mode, high = write-back
   input wire logic insn_boundary, // Core at instruction boundary
   input wire logic flush_busy, // Cache flush in progress
   input wire logic buffers_empty, // Write buffers drained
   input wire logic auto_halt, // Core in auto halt
   input wire logic soft_reset, // Soft reset request
   input wire logic flush_req, // Flush request
   input wire logic smi_req, // Management interrupt pending
   input wire logic nmi_req, // Nonmaskable pending
   input wire logic maskable_interrupt, // Maskable pending
   input wire logic [29:0] core_addr, // Last core address
   input wire logic [3:0] core_be_n, // Last core enables
   output logic core_clock_en, // Internal core clock enable
   output logic phase_one, // Phase one marker
   output logic prefetch_stop, // Stop prefetch unit
   output logic [2:0] winner, // Arbitration winner
   output logic resume_pulse, // Resume at next instruction
   output logic in_stop_grant // In stop grant state
);
   sclk_pkg::sclk_state_t state_r, state_nxt; // Sequence state
   logic stop_sync; // Synchronised request, low active
   logic [sclk_pkg::CNT_W-1:0] cnt_r; // Drain and resume counter
   logic hold_s; // Hold request from the chipset
   logic cycle_drive; // Grant cycle open in the next clock
   logic got_ack; // Ready or burst ready seen
   logic [2:0] win; // Arbitration result
   logic stop_wins; // Stop request wins arbitration
   logic [29:0] addr_r; // Held address
   logic [3:0] be_r; // Held enables
   logic ads_r; // Address strobe, low active
   logic hold_acknowledge_r; // Hold acknowledge
   logic hold_acknowledge_nxt; // Hold acknowledge for the next clock
   logic oe_r; // Address pins driven
   logic pull_r; // Stop request pull-up enabled
   logic cke_r; // Core clock enable
   logic ph_r; // Phase one marker
   logic pf_r; // Prefetch stopped
   logic res_r; // Resume strobe
   logic grant_r; // In stop grant
   logic [2:0] win_r; // Registered winner

   // Request is asynchronous; sample through two flops first
   sclk_sync #(.INIT(1'b1)) u_stop ( // R21
      .clk(clk), .reset(reset), .d(link.stop_clock_request_n), // R7
      .q(stop_sync));
   // Hold comes from chipset logic on this same clock, so no flops
   assign hold_s = link.hold;

   // Fixed priority; soft reset ranks by mode
   // Hard reset is the reset port itself, so it never reaches here
   function automatic logic [2:0] arb(input logic wb, input logic sr,
      input logic fl, input logic sm, input logic nm, input logic it,
      input logic st);
      logic [2:0] r;
      r = sclk_pkg::SCLK_SRC_NONE;
      if (sr && !wb) r = sclk_pkg::SCLK_SRC_SOFT_RESET; // R5
      else if (fl) r = sclk_pkg::SCLK_SRC_FLUSH; // R5
      else if (sr) r = sclk_pkg::SCLK_SRC_SOFT_RESET; // R6
      else if (sm) r = sclk_pkg::SCLK_SRC_SMI;
      else if (nm) r = sclk_pkg::SCLK_SRC_NMI;
      else if (it) r = sclk_pkg::SCLK_SRC_MASKABLE_INTERRUPT;
      else if (st) r = sclk_pkg::SCLK_SRC_STOP;
      return r;
   endfunction

   assign win = arb(write_back_mode, soft_reset, flush_req, smi_req,
                    nmi_req, maskable_interrupt, !stop_sync);
   // No recognition while bus granted away
   assign stop_wins = (win == sclk_pkg::SCLK_SRC_STOP) && !hold_acknowledge_r // R2
                      && insn_boundary; // R1
   assign got_ack = !link.ready_n || !link.burst_ready_n; // R12
   // Grant cycle open in the next clock; a hold must wait it out,
   // or the strobe and hold acknowledge would overlap on the bus
   assign cycle_drive = (state_nxt == sclk_pkg::SCLK_CYCLE) ||
                        (state_nxt == sclk_pkg::SCLK_WAIT_ACK);
   assign hold_acknowledge_nxt = hold_s && !cycle_drive; // R15

   // Next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         // Only an entry from run issues a grant cycle
         sclk_pkg::SCLK_RUN:
            if (stop_wins) state_nxt = sclk_pkg::SCLK_DRAIN; // R20
         sclk_pkg::SCLK_DRAIN:
            // Flush and buffers must settle before the cycle
            if (!flush_busy && buffers_empty && !hold_acknowledge_r && cnt_r == '0)
               state_nxt = sclk_pkg::SCLK_CYCLE; // R1
         sclk_pkg::SCLK_CYCLE:
            state_nxt = sclk_pkg::SCLK_WAIT_ACK;
         sclk_pkg::SCLK_WAIT_ACK:
            if (got_ack) state_nxt = sclk_pkg::SCLK_GRANT; // R12
         sclk_pkg::SCLK_GRANT:
            if (stop_sync) state_nxt = sclk_pkg::SCLK_RESUME; // R3
         sclk_pkg::SCLK_RESUME:
            if (cnt_r == '0) state_nxt = sclk_pkg::SCLK_RUN; // R19
         default:
            state_nxt = sclk_pkg::SCLK_RUN;
      endcase
   end

   // State, counter and registered pin drive
   always_ff @(posedge clk) begin
      if (reset) begin
         // Pins idle, pull-up on, core clock running
         state_r <= sclk_pkg::SCLK_RUN;
         cnt_r <= '0;
         addr_r <= '0;
         be_r <= sclk_pkg::QUIET_BE;
         ads_r <= 1'b1;
         hold_acknowledge_r <= 1'b0;
         oe_r <= 1'b0;
         pull_r <= 1'b1;
         cke_r <= 1'b1;
         ph_r <= 1'b0;
         pf_r <= 1'b0;
         res_r <= 1'b0;
         grant_r <= 1'b0;
         win_r <= '0;
      end else begin
         state_r <= state_nxt;
         // One counter serves drain and resume; they never overlap
         if (state_nxt == sclk_pkg::SCLK_DRAIN &&
             state_r == sclk_pkg::SCLK_RUN)
            cnt_r <= sclk_pkg::CNT_W'(sclk_pkg::DRAIN_CLKS - 1);
         else if (state_nxt == sclk_pkg::SCLK_RESUME &&
                  state_r == sclk_pkg::SCLK_GRANT)
            cnt_r <= sclk_pkg::CNT_W'(sclk_pkg::RESUME_CLKS - 1); // R19
         else if (cnt_r != '0)
            cnt_r <= cnt_r - 1'b1;
         // Grant cycle encoding; track core in run, frozen in every other state
         if (state_nxt == sclk_pkg::SCLK_CYCLE) begin
            addr_r <= sclk_pkg::STOP_GRANT_ADDR; // R11
            be_r <= sclk_pkg::STOP_GRANT_BE; // R11
         end else if (state_nxt == sclk_pkg::SCLK_RUN) begin
            addr_r <= core_addr;
            be_r <= core_be_n;
         end // R13
         ads_r <= !(state_nxt == sclk_pkg::SCLK_CYCLE); // R14
         hold_acknowledge_r <= hold_acknowledge_nxt; // R15
         // Address pins float under hold and come back after it
         oe_r <= !hold_acknowledge_nxt; // R16
         // Pull-up off saves the current the system now drives against
         pull_r <= (state_nxt != sclk_pkg::SCLK_GRANT); // R17
         // Core clock stays off from the grant cycle until the return to run
         cke_r <= (state_nxt == sclk_pkg::SCLK_RUN) ||
                  (state_nxt == sclk_pkg::SCLK_DRAIN); // R1
         // A flop cannot show half a period; marker only says running
         ph_r <= 1'b1; // R18
         pf_r <= (state_nxt != sclk_pkg::SCLK_RUN); // R1
         // Resume is plain continuation, no vector fetch
         res_r <= (state_r == sclk_pkg::SCLK_RESUME) &&
                  (state_nxt == sclk_pkg::SCLK_RUN) && !auto_halt; // R4
         grant_r <= (state_nxt == sclk_pkg::SCLK_GRANT);
         // Winner is registered so the output comes from a flop
         win_r <= win;
      end
   end

   // Bus pins; data never driven by this end, cycle data undefined
   // Cycle definition pins only ever carry the grant cycle, so tied;
   // the core's own bus cycles are not modelled by this end
   assign link.address_strobe_n = ads_r;
   assign link.addr = addr_r;
   assign link.byte_enables_n = be_r;
   assign link.mem_io = 1'b0;
   assign link.data_code = 1'b0;
   assign link.write_read = 1'b1;
   assign link.data_out = '0;
   assign link.data_oe = 1'b0; // R14
   assign link.data_parity = '0;
   assign link.data_parity_oe = 1'b0; // R14
   assign link.bus_lock_n = 1'b1; // R14
   assign link.pseudo_bus_lock_n = 1'b1; // R14
   assign link.hold_acknowledge = hold_acknowledge_r;
   assign link.addr_oe = oe_r;
   assign link.stop_pullup_en = pull_r;
   assign core_clock_en = cke_r;
   assign phase_one = ph_r;
   assign prefetch_stop = pf_r;
   assign winner = win_r;
   assign resume_pulse = res_r;
   assign in_stop_grant = grant_r;
endmodule

// File: hdl/sclk_sys.sv
// Chipset end: drives stop request, answers the grant cycle
module sclk_sys (
   input wire logic clk, // Clock
   input wire logic reset, // Sync reset, high
   sclk_link_if.sys link, // Bus pins
   input wire logic sleep_req, // User asks for stop grant
   input wire logic use_burst, // Answer with burst ready
   input wire logic hold_req, // User bus hold request
   output logic granted, // Grant cycle acknowledged
   output logic may_assert // Request may be raised again
);
   logic stop_n_r, rdy_r, burst_ready_n_r, hold_r, gr_r;
   logic [2:0] gap_r; // Clocks since request driven high
   logic is_grant_cycle; // Grant cycle on bus
   logic ads_s; // Strobe as seen by this end

   // Strobe comes from logic on this same clock, so no flops
   assign ads_s = link.address_strobe_n;

   assign is_grant_cycle = !ads_s &&
      link.addr == sclk_pkg::STOP_GRANT_ADDR &&
      link.byte_enables_n == sclk_pkg::STOP_GRANT_BE;

   // Request handling and acknowledge
   always_ff @(posedge clk) begin
      if (reset) begin
         stop_n_r <= 1'b1;
         rdy_r <= 1'b1;
         burst_ready_n_r <= 1'b1;
         hold_r <= 1'b0;
         gr_r <= 1'b0;
         gap_r <= 3'(sclk_pkg::REARM_CLKS);
      end else begin
         rdy_r <= !(is_grant_cycle && !use_burst); // R12
         burst_ready_n_r <= !(is_grant_cycle && use_burst); // R12
         hold_r <= hold_req;
         if (is_grant_cycle) begin
            gr_r <= 1'b1;
            gap_r <= '0;
         end else if (gap_r != 3'(sclk_pkg::REARM_CLKS) && stop_n_r)
            gap_r <= gap_r + 1'b1;
         // Keep low until acknowledged and sleep_req is low, then drive high
         if (stop_n_r && sleep_req &&
             gap_r == 3'(sclk_pkg::REARM_CLKS)) // R10
            stop_n_r <= 1'b0;
         else if (!stop_n_r && gr_r && !sleep_req) begin // R8
            stop_n_r <= 1'b1; // R9
            gr_r <= is_grant_cycle; // A new cycle in the same clock wins
         end
      end
   end

   assign link.stop_clock_request_n = stop_n_r;
   assign link.ready_n = rdy_r;
   assign link.burst_ready_n = burst_ready_n_r;
   assign link.hold = hold_r;
   assign link.data_in = '0;
   assign granted = gr_r;
   assign may_assert = (gap_r == 3'(sclk_pkg::REARM_CLKS));
endmodule

// File: test/sclk_properties.sv
// Concurrent checks on the pins between processor and chipset ends
module sclk_properties (
   input wire logic clk, // Clock
   input wire logic reset, // Sync reset, high
   input wire logic stop_clock_request_n, // Stop request
   input wire logic ready_n, // Ready
   input wire logic burst_ready_n, // Burst ready
   input wire logic hold, // Hold request
   input wire logic hold_acknowledge, // Hold granted
   input wire logic address_strobe_n, // Strobe
   input wire logic [29:0] addr, // Address
   input wire logic [3:0] byte_enables_n, // Enables
   input wire logic mem_io, // Cycle kind
   input wire logic data_code, // Cycle kind
   input wire logic write_read, // Cycle kind
   input wire logic data_oe, // Data drive
   input wire logic data_parity_oe, // Parity drive
   input wire logic bus_lock_n, // Lock
   input wire logic pseudo_bus_lock_n, // Pseudo lock
   input wire logic addr_oe, // Address drive
   input wire logic stop_pullup_en // Pull-up enable
);
   timeunit 1ns;
   timeprecision 1ps;
   // Either kind of ready ends the grant cycle
   wire logic ack_w = !ready_n || !burst_ready_n;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence ack_s;
      ack_w;
   endsequence
   sequence strobe_s;
      !address_strobe_n;
   endsequence
   a_cycle_code: assert property (strobe_s |-> addr == 30'h0000_0010 &&
      byte_enables_n == 4'hb && !mem_io && !data_code && write_read)
      else $error("Grant cycle encoding wrong");
   a_strobe_pulse: assert property (strobe_s |=> address_strobe_n)
      else $error("Strobe longer than one cycle");
   // A late answer would let the request go early, so the wait is bounded
   a_req_until_ack: assert property ($fell(address_strobe_n) |->
      !stop_clock_request_n throughout (##[0:40] ack_s))
      else $error("Request released before acknowledge");
   a_rearm_gap: assert property ($rose(stop_clock_request_n) |->
      stop_clock_request_n [*5]) else $error("Request re-raised too soon");
   a_data_float: assert property (!data_oe && !data_parity_oe)
      else $error("Data or parity driven");
   a_grant_idle: assert property (!stop_pullup_en |->
      bus_lock_n && pseudo_bus_lock_n && address_strobe_n)
      else $error("Strobe or lock active in grant");
   a_pullup_ack: assert property ($fell(stop_pullup_en) |->
      $past(ack_w) || $past(ack_w, 2)) else $error("Grant without ack");
   a_no_strobe_hold: assert property (hold_acknowledge |->
      address_strobe_n) else $error("Strobe during hold");
   a_hold_float: assert property (hold_acknowledge |-> !addr_oe)
      else $error("Address driven during hold");
   a_hold_acknowledge_cause: assert property ($rose(hold_acknowledge) |-> hold)
      else $error("Hold acknowledge without hold");
   a_addr_frozen: assert property (!stop_pullup_en && addr_oe &&
      $past(!stop_pullup_en && addr_oe) |-> $stable(addr) &&
      $stable(byte_enables_n)) else $error("Address moved in grant");
endmodule

// File: test/stop_clock_power_control_tb_top.sv
// Bench joining both ends through the link interface
module stop_clock_power_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset, write_back_mode, insn_boundary, flush_busy;
   logic buffers_empty, auto_halt, sleep_req, use_burst, hold_req;
   logic [29:0] core_addr; // Fixed core address
   logic [3:0] core_be_n; // Fixed core enables
   logic [4:0] req, r; // Requests, flush at bit 0
   wire logic flush_req, soft_reset, smi_req, nmi_req, maskable_interrupt;
   wire logic core_clock_en, phase_one, prefetch_stop, resume_pulse;
   wire logic in_stop_grant, granted, may_assert;
   wire logic [2:0] winner;
   int errors = 0, n_checks = 0, n_strobe = 0, n, m, k, j, s0;
   // Arbitration order, write-through first
   sclk_pkg::sclk_src_t ord [2][5] = '{
      '{sclk_pkg::SCLK_SRC_SOFT_RESET, sclk_pkg::SCLK_SRC_FLUSH,
        sclk_pkg::SCLK_SRC_SMI, sclk_pkg::SCLK_SRC_NMI,
        sclk_pkg::SCLK_SRC_MASKABLE_INTERRUPT},
      '{sclk_pkg::SCLK_SRC_FLUSH, sclk_pkg::SCLK_SRC_SOFT_RESET,
        sclk_pkg::SCLK_SRC_SMI, sclk_pkg::SCLK_SRC_NMI,
        sclk_pkg::SCLK_SRC_MASKABLE_INTERRUPT}};
   assign {maskable_interrupt, nmi_req, smi_req, soft_reset, flush_req} = req;
   sclk_link_if link();
   sclk_cpu sclk_cpu_inst (.clk, .reset, .link, .write_back_mode,
      .insn_boundary, .flush_busy, .buffers_empty, .auto_halt, .soft_reset,
      .flush_req, .smi_req, .nmi_req, .maskable_interrupt, .core_addr,
      .core_be_n, .core_clock_en, .phase_one, .prefetch_stop, .winner,
      .resume_pulse, .in_stop_grant);
   sclk_sys sclk_sys_inst (.clk, .reset, .link, .sleep_req, .use_burst,
      .hold_req, .granted, .may_assert);
   sclk_properties sclk_properties_inst (.clk, .reset,
      .stop_clock_request_n(link.stop_clock_request_n),
      .ready_n(link.ready_n), .burst_ready_n(link.burst_ready_n),
      .hold(link.hold), .hold_acknowledge(link.hold_acknowledge),
      .address_strobe_n(link.address_strobe_n), .addr(link.addr),
      .byte_enables_n(link.byte_enables_n), .mem_io(link.mem_io),
      .data_code(link.data_code), .write_read(link.write_read),
      .data_oe(link.data_oe), .data_parity_oe(link.data_parity_oe),
      .bus_lock_n(link.bus_lock_n),
      .pseudo_bus_lock_n(link.pseudo_bus_lock_n),
      .addr_oe(link.addr_oe), .stop_pullup_en(link.stop_pullup_en));
   // Free-running clock, 8 ns period
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   // Count grant cycles seen on the strobe
   always @(posedge clk) begin
      if (!reset && link.address_strobe_n === 1'b0) n_strobe <= n_strobe + 1;
   end
   task check(input string what, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task stop_test;
      $display("Checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Bounded wait; a level settles 1 ns after the edge
   task wait_on(input int sel, input logic v);
      logic [4:0] w;
      for (n = 0; n < 300; n++) begin
         @(posedge clk);
         #1;
         w = {may_assert, resume_pulse, link.stop_clock_request_n,
              link.hold_acknowledge, in_stop_grant};
         if (w[sel] === v) break;
      end
      check("wait", n < 300, 1);
   endtask
   // One entry to grant, a hold inside it, and the wake-up
   task sleep_wake;
      @(posedge clk) sleep_req <= 1;
      wait_on(0, 1);
      check("granted", granted, 1);
      check("clock_en", core_clock_en, 0);
      check("prefetch", prefetch_stop, 1);
      check("pullup", link.stop_pullup_en, 0);
      check("strobes", n_strobe - s0, 1);
      check("be", link.byte_enables_n, sclk_pkg::STOP_GRANT_BE);
      @(posedge clk) hold_req <= 1;
      wait_on(1, 1);
      check("addr_oe", link.addr_oe, 0);
      @(posedge clk) hold_req <= 0;
      wait_on(1, 0);
      repeat (2) @(posedge clk);
      #1;
      check("addr", link.addr, sclk_pkg::STOP_GRANT_ADDR);
      check("in_grant", in_stop_grant, 1);
      check("addr_back", link.addr_oe, 1);
      @(posedge clk) sleep_req <= 0;
      wait_on(2, 1);
      wait_on(3, 1);
      check("resume", n + 1 >= 10 && n + 1 <= 20, 1);
      check("clock_en", core_clock_en, 1);
      check("no_ack_cycle", n_strobe - s0, 1);
      check("phase", phase_one, 1);
      wait_on(4, 1);
   endtask
   // Watchdog: far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("Error watchdog expired");
      stop_test;
   end
   initial begin
      {reset, write_back_mode, insn_boundary, flush_busy} = 4'h8;
      {buffers_empty, auto_halt, sleep_req, use_burst, hold_req} = 5'h00;
      core_addr = 30'h0000_1234;
      core_be_n = 4'h0;
      req = 5'h00;
      repeat (16) @(posedge clk);
      reset <= 0;
      // Walk down each priority list, dropping the winner each step
      for (m = 0; m < 2; m++) begin
         for (k = 0; k <= 5; k++) begin
            r = 5'h00;
            for (j = k; j < 5; j++) r[ord[m][j] - 2] = 1'b1;
            @(posedge clk) write_back_mode <= m[0];
            req <= r;
            repeat (3) @(posedge clk);
            #1;
            check("winner", winner, k == 5 ? 0 : ord[m][k]);
         end
      end
      // Core busy and off a boundary: no grant cycle yet
      @(posedge clk) req <= 5'h00;
      {flush_busy, sleep_req} <= 2'h3;
      repeat (30) @(posedge clk);
      #1;
      check("early", {in_stop_grant, n_strobe[7:0]}, 0);
      check("winner", winner, sclk_pkg::SCLK_SRC_STOP);
      s0 = n_strobe;
      @(posedge clk) {insn_boundary, flush_busy, buffers_empty} <= 3'h5;
      sleep_wake;
      // Request under hold is not acted on; burst ready answers
      @(posedge clk) {hold_req, use_burst} <= 2'h3;
      wait_on(1, 1);
      s0 = n_strobe;
      @(posedge clk) sleep_req <= 1;
      repeat (30) @(posedge clk);
      #1;
      check("hold_block", n_strobe - s0, 0);
      check("hold_grant", in_stop_grant, 0);
      @(posedge clk) hold_req <= 0;
      sleep_wake;
      stop_test;
   end
endmodule
